// ---- hdl/usb_ep0_out_regs.vh ----
// Register offsets, field positions and reset values of the ep0 out block
`ifndef USB_EP0_OUT_REGS_VH
`define USB_EP0_OUT_REGS_VH

// ********************
// Register byte offsets
// ********************
`define OFS_EP0_OUT_CONFIG 12'h000
`define OFS_EP0_OUT_BYTE_COUNT 12'h004
`define OFS_FUNCTION_ADDRESS 12'h008
`define OFS_USB_EVENT_STATUS 12'h00c
`define OFS_USB_EVENT_MASK 12'h010
`define OFS_EP0_EVENT_STATUS 12'h014

// ********************
// ep0_out_config fields
// ********************
`define BIT_XFER_DONE_IRQ_ENABLE 2
`define BIT_STALL 3
`define BIT_DATA_TOGGLE_STATE 5
`define BIT_BUFFER_MANAGER_ENABLE 7

// ********************
// ep0_out_byte_count fields
// ********************
`define BIT_NAK 7
`define COUNT_MAX 4'h8
`define RST_COUNT 4'h0
`define RST_NAK 1'b1
`define RST_CFG_BIT 1'h0
`define RST_XFER 1'h0

// ********************
// usb_event_status and usb_event_mask fields
// ********************
`define BIT_SETUP_OVERWRITE_FLAG 0
`define BIT_SETUP_FLAG 2
`define BIT_PORT3_POWER_ON_FLAG 3
`define BIT_PORT3_POWER_OFF_FLAG 4
`define BIT_RESUME_FLAG 5
`define BIT_SUSPEND_FLAG 6
`define BIT_PORT_RESET_FLAG 7
`define STATUS_IMPL_MASK 8'hfd
`define RST_STATUS 8'h00
`define RST_MASK 8'h00
`define RST_ADDRESS 7'h00

// ********************
// Handshake codes
// ********************
`define HS_ACK 2'h0
`define HS_NAK 2'h1
`define HS_STALL 2'h2

`endif

// ---- hdl/usb_ep0_out_status.v ----
// Endpoint-0 out control, function address and USB event status logic
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "usb_ep0_out_regs.vh"

module usb_ep0_out_status
(
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // USB engine events, one-cycle pulses
    input wire usb_func_reset,
    input wire setup_rx,
    input wire setup_buf_full,
    input wire out_pkt_rx,
    input wire [6:0] token_addr,
    input wire [3:0] out_pkt_len,
    input wire out_pkt_data1,
    input wire port3_power_on,
    input wire port3_power_off,
    input wire resume_detect,
    input wire suspend_detect,
    input wire port_reset_detect,
    // Handshake to USB engine
    output reg hs_valid,
    output reg [1:0] hs_code,
    // Interrupt
    output reg irq
);

    // ********************
    // State
    // ********************
    reg ie_q;
    reg stall_q;
    reg toggle_q;
    reg bm_enable_q;
    reg nak_q;
    reg [3:0] count_q;
    reg [6:0] address_field_q;
    reg [7:0] sta_q;
    reg [7:0] msk_q;
    reg xfer_flag_q;

    // ********************
    // Bus decode
    // ********************
    wire acc = psel & penable;
    wire wr = acc & pwrite & pready;
    wire hit_cfg = paddr == `OFS_EP0_OUT_CONFIG;
    wire hit_cnt = paddr == `OFS_EP0_OUT_BYTE_COUNT;
    wire hit_adr = paddr == `OFS_FUNCTION_ADDRESS;
    wire hit_sta = paddr == `OFS_USB_EVENT_STATUS;
    wire hit_msk = paddr == `OFS_USB_EVENT_MASK;
    wire hit_evt = paddr == `OFS_EP0_EVENT_STATUS;
    wire mapped = hit_cfg | hit_cnt | hit_adr | hit_sta | hit_msk | hit_evt;

    // ********************
    // Transaction decisions
    // ********************
    wire addr_ok = token_addr == address_field_q;
    wire setup_ev = setup_rx & addr_ok;
    wire out_ev = out_pkt_rx & addr_ok;
    wire out_stall = out_ev & stall_q;
    // Refusal: setup pending, buffer full or manager blocked
    wire out_nak = out_ev & ~stall_q &
        (sta_q[`BIT_SETUP_FLAG] | nak_q | ~bm_enable_q);
    wire out_ack = out_ev & ~stall_q & ~out_nak;
    wire out_take = out_ack & (out_pkt_data1 == toggle_q);

    function [3:0] clamp;
        input [3:0] v;
        begin
            clamp = (v > `COUNT_MAX) ? `COUNT_MAX : v;
        end
    endfunction

    // ********************
    // Status set vector
    // ********************
    reg [7:0] set_vec;
    always @*
    begin
        set_vec = 8'h00;
        set_vec[`BIT_SETUP_OVERWRITE_FLAG] = setup_ev & setup_buf_full;
        set_vec[`BIT_SETUP_FLAG] = setup_ev;
        set_vec[`BIT_PORT3_POWER_ON_FLAG] = port3_power_on;
        set_vec[`BIT_PORT3_POWER_OFF_FLAG] = port3_power_off;
        set_vec[`BIT_RESUME_FLAG] = resume_detect;
        set_vec[`BIT_SUSPEND_FLAG] = suspend_detect;
        set_vec[`BIT_PORT_RESET_FLAG] = port_reset_detect;
    end

    wire [7:0] sta_clr = (wr & hit_sta) ? pwdata[7:0] : 8'h00;
    wire [7:0] sta_keep = usb_func_reset ? (sta_q & 8'h80) : sta_q;
    wire [7:0] sta_d;

    // ********************
    // Event status flags, one per implemented bit, bit 1 held at zero
    // ********************
    localparam [7:0] STA_IMPL = `STATUS_IMPL_MASK;
    genvar b;
    generate
        for (b = 0; b < 8; b = b + 1)
        begin : g_sta
            // Set wins over a write-one clear
            assign sta_d[b] = STA_IMPL[b] &
                ((sta_keep[b] & ~sta_clr[b]) | set_vec[b]);
        end
    endgenerate

    // ********************
    // Event status register
    // ********************
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            sta_q <= `RST_STATUS;
        else
            sta_q <= sta_d;
    end

    // ********************
    // Transfer interrupt enable
    // ********************
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            ie_q <= `RST_CFG_BIT;
        else if (usb_func_reset)
            ie_q <= `RST_CFG_BIT;
        else if (wr & hit_cfg)
            ie_q <= pwdata[`BIT_XFER_DONE_IRQ_ENABLE];
    end

    // ********************
    // Stall request, cleared when sent or by a setup
    // ********************
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            stall_q <= `RST_CFG_BIT;
        else if (usb_func_reset)
            stall_q <= `RST_CFG_BIT;
        else if (out_stall | setup_ev)
            stall_q <= 1'h0;
        else if (wr & hit_cfg)
            stall_q <= pwdata[`BIT_STALL];
    end

    // ********************
    // Data toggle, a setup starts DATA1
    // ********************
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            toggle_q <= `RST_CFG_BIT;
        else if (usb_func_reset)
            toggle_q <= `RST_CFG_BIT;
        else if (setup_ev)
            toggle_q <= 1'h1;
        else if (out_take)
            toggle_q <= ~toggle_q;
    end

    // ********************
    // Buffer manager enable
    // ********************
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            bm_enable_q <= `RST_CFG_BIT;
        else if (usb_func_reset)
            bm_enable_q <= `RST_CFG_BIT;
        else if (wr & hit_cfg)
            bm_enable_q <= pwdata[`BIT_BUFFER_MANAGER_ENABLE];
    end

    // ********************
    // Buffer NAK, packet load wins over a software write
    // ********************
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            nak_q <= `RST_NAK;
        else if (usb_func_reset)
            nak_q <= `RST_NAK;
        else if (out_take)
            nak_q <= 1'h1;
        else if (wr & hit_cnt)
            nak_q <= pwdata[`BIT_NAK];
    end

    // ********************
    // Byte count load, reserved codes act as 8
    // ********************
    wire [3:0] count_load = out_take ? clamp(out_pkt_len) :
        clamp(pwdata[3:0]);

    // ********************
    // Byte count
    // ********************
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            count_q <= `RST_COUNT;
        else if (usb_func_reset)
            count_q <= `RST_COUNT;
        else if (out_take | (wr & hit_cnt))
            count_q <= count_load;
    end

    // ********************
    // Function address
    // ********************
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            address_field_q <= `RST_ADDRESS;
        else if (usb_func_reset)
            address_field_q <= `RST_ADDRESS;
        else if (wr & hit_adr)
            address_field_q <= pwdata[6:0];
    end

    // ********************
    // Event mask
    // ********************
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            msk_q <= `RST_MASK;
        else if (usb_func_reset)
            msk_q <= `RST_MASK;
        else if (wr & hit_msk)
            msk_q <= pwdata[7:0] & STA_IMPL;
    end

    // ********************
    // Transfer-done event
    // ********************
    wire xfer_set = out_take & ie_q;
    wire xfer_clr = wr & hit_evt & pwdata[0];

    // ********************
    // Transfer-done flag, set wins over clear
    // ********************
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            xfer_flag_q <= `RST_XFER;
        else if (usb_func_reset)
            xfer_flag_q <= `RST_XFER;
        else if (xfer_set)
            xfer_flag_q <= 1'h1;
        else if (xfer_clr)
            xfer_flag_q <= 1'h0;
    end

    // ********************
    // Handshake strobe
    // ********************
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            hs_valid <= 1'h0;
        else
            hs_valid <= out_ev;
    end

    // ********************
    // Handshake code
    // ********************
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            hs_code <= `HS_ACK;
        // Stall outranks NAK, NAK outranks ACK
        else if (out_stall)
            hs_code <= `HS_STALL;
        else if (out_nak)
            hs_code <= `HS_NAK;
        else
            hs_code <= `HS_ACK;
    end

    // ********************
    // Interrupt, follows the next event status and the current transfer-done flag
    // ********************
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'h0;
        else
            irq <= |(sta_d & msk_q) | xfer_flag_q;
    end

    // ********************
    // APB response, one wait state
    // ********************
    reg [7:0] rd_byte;
    always @*
    begin
        rd_byte = 8'h00;
        if (hit_cfg)
        begin
            rd_byte[`BIT_XFER_DONE_IRQ_ENABLE] = ie_q;
            rd_byte[`BIT_STALL] = stall_q;
            rd_byte[`BIT_DATA_TOGGLE_STATE] = toggle_q;
            rd_byte[`BIT_BUFFER_MANAGER_ENABLE] = bm_enable_q;
        end
        else if (hit_cnt)
            rd_byte = {nak_q, 3'h0, count_q};
        else if (hit_adr)
            rd_byte = {1'b0, address_field_q};
        else if (hit_sta)
            rd_byte = sta_q;
        else if (hit_msk)
            rd_byte = msk_q;
        else if (hit_evt)
            rd_byte = {7'h00, xfer_flag_q};
    end

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= acc & ~pready;
            pslverr <= acc & ~pready & ~mapped;
            if (acc & ~pready & ~pwrite)
                prdata <= {24'h000000, rd_byte};
        end
    end

endmodule

// ---- testbench/ep0_out_props.sv ----
// Assertion checker for the ep0 out and status block
`timescale 1ns/1ps
`include "usb_ep0_out_regs.vh"
module ep0_out_props
(
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // USB events
    input wire usb_func_reset,
    input wire setup_rx,
    input wire out_pkt_rx,
    input wire port3_power_on,
    // Handshake and interrupt
    input wire hs_valid,
    input wire [1:0] hs_code,
    input wire irq
);
    reg [7:0] msk_q;
    // Mirror of the event mask
    always @(posedge core_clk or negedge rst_n)
        if (!rst_n || usb_func_reset)
            msk_q <= 8'h00;
        else if (psel && penable && pready && pwrite &&
            paddr == `OFS_USB_EVENT_MASK)
            msk_q <= pwdata[7:0];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_setup_out;
        setup_rx ##2 out_pkt_rx ##1 hs_valid;
    endsequence
    sequence s_stall_out;
        hs_valid && hs_code == `HS_STALL ##1 out_pkt_rx ##1 hs_valid;
    endsequence
    a_pready_one_wait:
    assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_pready_pulse:
    assert property (pready |=> !pready)
        else $error("pready held");
    a_err_with_ready:
    assert property (pslverr |-> pready)
        else $error("pslverr alone");
    a_reserved_read_zero:
    assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    a_hs_after_out:
    assert property (hs_valid |-> $past(out_pkt_rx))
        else $error("handshake without out");
    a_setup_forces_nak:
    assert property (s_setup_out |-> hs_code == `HS_NAK)
        else $error("out not refused after setup");
    a_stall_once:
    assert property (s_stall_out |-> hs_code != `HS_STALL)
        else $error("stall repeated");
    a_power_on_irq:
    assert property (port3_power_on && msk_q[3] |-> ##[1:2] irq)
        else $error("power on irq missing");
    a_hs_code_legal:
    assert property (hs_valid |-> hs_code != 2'h3)
        else $error("bad handshake code");
endmodule
bind usb_ep0_out_status ep0_out_props chk_u (.*);

// ---- testbench/usb_host_model.sv ----
// Behavioural USB host issuing setup and OUT tokens
`timescale 1ns/1ps
module usb_host_model
(
    // Clock and handshake
    input wire core_clk,
    input wire hs_valid,
    input wire [1:0] hs_code,
    // Token side
    output reg setup_rx = 1'b0,
    output reg setup_buf_full = 1'b0,
    output reg out_pkt_rx = 1'b0,
    output reg [6:0] token_addr = 7'h7f,
    output reg [3:0] out_pkt_len = 4'h0,
    output reg out_pkt_data1 = 1'b0
);
    reg got_hs = 1'b0;
    reg [1:0] got_code = 2'h0;
    // One token; for a setup, pid gives the buffer-full level
    task send(input reg stp, input reg [6:0] a, input reg [3:0] n,
        input reg pid);
    begin
        @(posedge core_clk);
        setup_rx <= stp;
        out_pkt_rx <= !stp;
        setup_buf_full <= pid;
        token_addr <= a;
        out_pkt_len <= n;
        out_pkt_data1 <= pid;
        @(posedge core_clk);
        setup_rx <= 1'b0;
        out_pkt_rx <= 1'b0;
        setup_buf_full <= !pid;
        token_addr <= ~a;
        out_pkt_len <= ~n;
        out_pkt_data1 <= !pid;
        #1;
        got_hs = hs_valid;
        got_code = hs_code;
    end
    endtask
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the ep0 out and status block
`timescale 1ns/1ps
`include "usb_ep0_out_regs.vh"
module tb;
    reg core_clk = 1'b0;
    reg rst_n = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg [5:0] ev = 6'h00;
    reg [31:0] rd;
    reg er;
    integer errors = 0;
    integer check_count = 0;
    integer k;
    wire [31:0] prdata;
    wire pready, pslverr, hs_valid, irq, setup_rx, setup_buf_full;
    wire out_pkt_rx, out_pkt_data1;
    wire [6:0] token_addr;
    wire [3:0] out_pkt_len;
    wire [1:0] hs_code;
    wire port3_power_on = ev[0];
    wire port3_power_off = ev[1];
    wire resume_detect = ev[2];
    wire suspend_detect = ev[3];
    wire port_reset_detect = ev[4];
    wire usb_func_reset = ev[5];
    usb_ep0_out_status dut_u (.*);
    usb_host_model host_u (.*);
    always #2.5 core_clk = ~core_clk;
    task check(input string what, input logic [31:0] got, exp);
    begin
        check_count = check_count + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    end
    endtask
    task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
    begin
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask
    task wr(input reg [11:0] a, input reg [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task rdc(input string w, input reg [11:0] a, input reg [31:0] e);
    begin
        apb(1'b0, a, 32'h0);
        check(w, rd, e);
    end
    endtask
    task pulse(input integer b);
    begin
        @(posedge core_clk);
        ev <= 6'h01 << b;
        @(posedge core_clk);
        ev <= 6'h00;
    end
    endtask
    // ********************
    // Scenarios
    // ********************
    task t_reset;
    begin
        rdc("config", `OFS_EP0_OUT_CONFIG, 32'h00);
        rdc("count", `OFS_EP0_OUT_BYTE_COUNT, 32'h80);
        rdc("mask", `OFS_USB_EVENT_MASK, 32'h00);
        wr(`OFS_FUNCTION_ADDRESS, 8'hff);
        rdc("address", `OFS_FUNCTION_ADDRESS, 32'h7f);
        rdc("unmapped", 12'h018, 32'h0);
        check("slverr", er, 1);
    end
    endtask
    task t_out;
    begin
        wr(`OFS_FUNCTION_ADDRESS, 8'h05);
        wr(`OFS_EP0_OUT_BYTE_COUNT, 8'h00);
        host_u.send(0, 7'h05, 4'h3, 0);
        check("gated", host_u.got_code, `HS_NAK);
        wr(`OFS_EP0_OUT_CONFIG, 8'h80);
        host_u.send(0, 7'h06, 4'h3, 0);
        check("foreign", host_u.got_hs, 0);
        host_u.send(0, 7'h05, 4'hf, 0);
        check("ack", host_u.got_code, `HS_ACK);
        check("quiet", irq, 0);
        rdc("count", `OFS_EP0_OUT_BYTE_COUNT, 32'h88);
        rdc("toggle", `OFS_EP0_OUT_CONFIG, 32'ha0);
        host_u.send(0, 7'h05, 4'h1, 1);
        check("full", host_u.got_code, `HS_NAK);
        wr(`OFS_EP0_OUT_CONFIG, 8'h84);
        wr(`OFS_EP0_OUT_BYTE_COUNT, 8'h09);
        rdc("clamp", `OFS_EP0_OUT_BYTE_COUNT, 32'h08);
        host_u.send(0, 7'h05, 4'h2, 1);
        rdc("done", `OFS_EP0_EVENT_STATUS, 32'h01);
        check("irq", irq, 1);
        wr(`OFS_EP0_EVENT_STATUS, 8'h01);
        rdc("done", `OFS_EP0_EVENT_STATUS, 32'h00);
        check("irq", irq, 0);
    end
    endtask
    task t_stall;
    begin
        wr(`OFS_EP0_OUT_CONFIG, 8'h88);
        host_u.send(0, 7'h05, 4'h1, 0);
        check("stall", host_u.got_code, `HS_STALL);
        host_u.send(0, 7'h05, 4'h1, 0);
        check("after", host_u.got_code, `HS_NAK);
        rdc("config", `OFS_EP0_OUT_CONFIG, 32'h80);
    end
    endtask
    task t_setup;
    begin
        wr(`OFS_USB_EVENT_MASK, 8'h05);
        wr(`OFS_EP0_OUT_BYTE_COUNT, 8'h00);
        host_u.send(1, 7'h05, 4'h0, 0);
        host_u.send(0, 7'h05, 4'h1, 1);
        check("setup", host_u.got_code, `HS_NAK);
        rdc("status", `OFS_USB_EVENT_STATUS, 32'h04);
        check("irq", irq, 1);
        host_u.send(1, 7'h05, 4'h0, 1);
        rdc("status", `OFS_USB_EVENT_STATUS, 32'h05);
        wr(`OFS_USB_EVENT_STATUS, 8'h00);
        rdc("keep", `OFS_USB_EVENT_STATUS, 32'h05);
        wr(`OFS_USB_EVENT_STATUS, 8'h05);
        rdc("clear", `OFS_USB_EVENT_STATUS, 32'h00);
        check("irq", irq, 0);
    end
    endtask
    task t_events;
    begin
        wr(`OFS_USB_EVENT_MASK, 8'h08);
        for (k = 0; k < 5; k = k + 1)
        begin
            pulse(k);
            rdc("event", `OFS_USB_EVENT_STATUS, 32'h8 << k);
            wr(`OFS_USB_EVENT_STATUS, 8'hff);
        end
        pulse(4);
        pulse(5);
        rdc("reset", `OFS_USB_EVENT_STATUS, 32'h80);
        rdc("mask", `OFS_USB_EVENT_MASK, 32'h00);
    end
    endtask
    task tally_and_finish;
    begin
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    initial
    begin
        #50000;
        errors = errors + 1;
        tally_and_finish;
    end
    initial
    begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset;
        t_out;
        t_stall;
        t_setup;
        t_events;
        tally_and_finish;
    end
endmodule
